// ===== rtl/bstap_defs.vh
`ifndef BSTAP_DEFS_VH
`define BSTAP_DEFS_VH

// Instruction width and codes
`define BSTAP_IR_W 4
`define BSTAP_IR_BYPASS 4'h0
`define BSTAP_IR_SAMPLE 4'h1
`define BSTAP_IR_IDCODE 4'h2
`define BSTAP_IR_USERCODE 4'h3
`define BSTAP_IR_CLAMP 4'h4
`define BSTAP_IR_HIGHZ 4'h5
`define BSTAP_IR_EXTEST 4'h7
`define BSTAP_IR_IFONOFF 4'h8
`define BSTAP_IR_REGRD 4'h9
`define BSTAP_IR_REGWR 4'hA
// Fixed pattern captured into the instruction chain
`define BSTAP_IR_CAPT 4'h1

// Data chain lengths
`define BSTAP_DR_W 32
`define BSTAP_LEN_BYPASS 6'h01
`define BSTAP_LEN_BSR 6'h18
`define BSTAP_LEN_ID 6'h20
`define BSTAP_LEN_IF 6'h01
`define BSTAP_LEN_REG 6'h0F

// Boundary chain: 12 pins, control and data cell each
`define BSTAP_PINS 12
`define BSTAP_BSR_W 24

// Register access fields
`define BSTAP_ADDR_W 7
`define BSTAP_DATA_W 8
`define BSTAP_WR_W 15

// Clocks after reset before test clock edges are trusted
`define BSTAP_SYNC_WAIT 2'h3

// Identification code, arbitrary value, bit 0 set as required
`define BSTAP_IDCODE_VAL 32'h1A5C_E0F1

`endif

// ===== rtl/bstap_sync.v
`timescale 1ns/10ps
`default_nettype none

module bstap_sync #(
  parameter WIDTH = 1
) (
  input wire mclk_i,
  input wire nrst_i,
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta;

  // Two flops; the first is read only by the second
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      meta <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule

`default_nettype wire

// ===== rtl/bstap_buf2.v
`timescale 1ns/10ps
`default_nettype none

module bstap_buf2 #(
  parameter WIDTH = 15
) (
  input wire mclk_i,
  input wire nrst_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output reg out_valid_o,
  input wire out_ready_i,
  output reg [WIDTH-1:0] out_data_o
);

  reg [WIDTH-1:0] slot1;
  reg valid1;
  wire push;
  wire pop;

  // Ready drops only when both slots hold a word
  assign in_ready_o = ~valid1;
  assign push = in_valid_i & ~valid1;
  assign pop = out_valid_o & out_ready_i;

  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      out_valid_o <= 1'b0;
      valid1 <= 1'b0;
      out_data_o <= {WIDTH{1'b0}};
      slot1 <= {WIDTH{1'b0}};
    end else if (pop && valid1) begin
      out_data_o <= slot1;
      out_valid_o <= 1'b1;
      valid1 <= push;
      if (push) begin
        slot1 <= in_data_i;
      end
    end else if (pop) begin
      out_valid_o <= push;
      if (push) begin
        out_data_o <= in_data_i;
      end
    end else if (push && !out_valid_o) begin
      out_data_o <= in_data_i;
      out_valid_o <= 1'b1;
    end else if (push) begin
      slot1 <= in_data_i;
      valid1 <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// ===== rtl/bstap_top.v
`timescale 1ns/10ps
`default_nettype none
`include "bstap_defs.vh"

module bstap_top (
  input wire mclk_i,
  input wire nrst_i,
  input wire tck_i,
  input wire tms_i,
  input wire tdi_i,
  output reg tdo_o,
  output reg tdo_oe_o,
  input wire [`BSTAP_PINS-1:0] pin_in_i,
  input wire [`BSTAP_PINS-1:0] core_out_i,
  input wire [`BSTAP_PINS-1:0] core_oe_i,
  output reg [`BSTAP_PINS-1:0] pin_out_o,
  output reg [`BSTAP_PINS-1:0] pin_oe_o,
  input wire [31:0] nvm_user_i,
  output reg host_if_off_o,
  output reg [`BSTAP_ADDR_W-1:0] reg_rd_addr_o,
  input wire [`BSTAP_DATA_W-1:0] reg_rd_data_i,
  output wire reg_wr_valid_o,
  input wire reg_wr_ready_i,
  output wire [`BSTAP_ADDR_W-1:0] reg_wr_addr_o,
  output wire [`BSTAP_DATA_W-1:0] reg_wr_data_o,
  output reg wr_overrun_o
);

  localparam [3:0] ST_TLR = 4'h0;
  localparam [3:0] ST_RTI = 4'h1;
  localparam [3:0] ST_SEL_DR = 4'h2;
  localparam [3:0] ST_CAP_DR = 4'h3;
  localparam [3:0] ST_SH_DR = 4'h4;
  localparam [3:0] ST_EX1_DR = 4'h5;
  localparam [3:0] ST_PAU_DR = 4'h6;
  localparam [3:0] ST_EX2_DR = 4'h7;
  localparam [3:0] ST_UPD_DR = 4'h8;
  localparam [3:0] ST_SEL_IR = 4'h9;
  localparam [3:0] ST_CAP_IR = 4'hA;
  localparam [3:0] ST_SH_IR = 4'hB;
  localparam [3:0] ST_EX1_IR = 4'hC;
  localparam [3:0] ST_PAU_IR = 4'hD;
  localparam [3:0] ST_EX2_IR = 4'hE;
  localparam [3:0] ST_UPD_IR = 4'hF;

  // Next controller state from state and sampled mode select
  function [3:0] tap_next;
    input [3:0] st;
    input tms;
    begin
      case (st)
        ST_TLR: tap_next = tms ? ST_TLR : ST_RTI;
        ST_RTI: tap_next = tms ? ST_SEL_DR : ST_RTI;
        ST_SEL_DR: tap_next = tms ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: tap_next = tms ? ST_UPD_DR : ST_PAU_DR;
        ST_PAU_DR: tap_next = tms ? ST_EX2_DR : ST_PAU_DR;
        ST_EX2_DR: tap_next = tms ? ST_UPD_DR : ST_SH_DR;
        ST_UPD_DR: tap_next = tms ? ST_SEL_DR : ST_RTI;
        ST_SEL_IR: tap_next = tms ? ST_TLR : ST_CAP_IR;
        ST_CAP_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: tap_next = tms ? ST_UPD_IR : ST_PAU_IR;
        ST_PAU_IR: tap_next = tms ? ST_EX2_IR : ST_PAU_IR;
        ST_EX2_IR: tap_next = tms ? ST_UPD_IR : ST_SH_IR;
        ST_UPD_IR: tap_next = tms ? ST_SEL_DR : ST_RTI;
        default: tap_next = ST_TLR;
      endcase
    end
  endfunction

  // Selected data chain length per instruction
  function [5:0] dr_len;
    input [`BSTAP_IR_W-1:0] ir;
    begin
      case (ir)
        `BSTAP_IR_SAMPLE: dr_len = `BSTAP_LEN_BSR;
        `BSTAP_IR_EXTEST: dr_len = `BSTAP_LEN_BSR;
        `BSTAP_IR_IDCODE: dr_len = `BSTAP_LEN_ID;
        `BSTAP_IR_USERCODE: dr_len = `BSTAP_LEN_ID;
        `BSTAP_IR_IFONOFF: dr_len = `BSTAP_LEN_IF;
        `BSTAP_IR_REGRD: dr_len = `BSTAP_LEN_REG;
        `BSTAP_IR_REGWR: dr_len = `BSTAP_LEN_REG;
        default: dr_len = `BSTAP_LEN_BYPASS;
      endcase
    end
  endfunction

  // Shift right by one, new bit enters at the chain's last stage
  function [`BSTAP_DR_W-1:0] shift_in;
    input [`BSTAP_DR_W-1:0] sh;
    input din;
    input [5:0] len;
    reg [`BSTAP_DR_W-1:0] tmp;
    integer i;
    begin
      tmp = sh >> 1;
      for (i = 0; i < `BSTAP_DR_W; i = i + 1) begin
        if (i == len - 1) begin
          tmp[i] = din;
        end
      end
      shift_in = tmp;
    end
  endfunction

  wire [2:0] jtag_s;
  wire [`BSTAP_PINS-1:0] pin_in_s;
  wire tck_s;
  wire tms_s;
  wire tdi_s;
  wire tck_rise;
  wire tck_fall;
  wire buf_in_ready;
  wire [5:0] cur_len;
  wire test_drive;
  wire armed;

  reg tck_d;
  reg [1:0] warm;
  reg [3:0] state;
  reg [`BSTAP_IR_W-1:0] ir;
  reg [`BSTAP_IR_W-1:0] ir_sh;
  reg [`BSTAP_DR_W-1:0] dr_sh;
  reg [`BSTAP_BSR_W-1:0] bsr_upd;
  reg wr_push;
  reg [`BSTAP_WR_W-1:0] wr_word;
  reg [`BSTAP_DR_W-1:0] capt;
  reg [`BSTAP_PINS-1:0] next_pin_out;
  reg [`BSTAP_PINS-1:0] next_pin_oe;
  integer k;
  integer m;

  bstap_sync #(
    .WIDTH(3)
  ) u_jtag_sync (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .async_i({tck_i, tms_i, tdi_i}),
    .sync_o(jtag_s)
  );

  bstap_sync #(
    .WIDTH(`BSTAP_PINS)
  ) u_pin_sync (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .async_i(pin_in_i),
    .sync_o(pin_in_s)
  );

  bstap_buf2 #(
    .WIDTH(`BSTAP_WR_W)
  ) u_wr_buf (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .in_valid_i(wr_push),
    .in_ready_o(buf_in_ready),
    .in_data_i(wr_word),
    .out_valid_o(reg_wr_valid_o),
    .out_ready_i(reg_wr_ready_i),
    .out_data_o({reg_wr_data_o, reg_wr_addr_o})
  );

  assign tck_s = jtag_s[2];
  assign tms_s = jtag_s[1];
  assign tdi_s = jtag_s[0];
  // Controller, chains and serial output move only on a test clock edge; pin drive is registered every clock
  // No edge until the synchroniser has flushed, so an idle-high pin gives no false edge
  assign armed = (warm == `BSTAP_SYNC_WAIT);
  assign tck_rise = tck_s & ~tck_d & armed;
  assign tck_fall = ~tck_s & tck_d & armed;
  assign cur_len = dr_len(ir);
  assign test_drive = (ir == `BSTAP_IR_EXTEST) || (ir == `BSTAP_IR_CLAMP);

  // Capture value of the selected data chain
  always @* begin
    k = 0;
    capt = {`BSTAP_DR_W{1'b0}};
    case (ir)
      `BSTAP_IR_SAMPLE, `BSTAP_IR_EXTEST: begin
        for (k = 0; k < `BSTAP_PINS; k = k + 1) begin
          capt[2*k] = pin_in_s[k];
          capt[2*k+1] = pin_oe_o[k];
        end
      end
      `BSTAP_IR_IDCODE: capt = `BSTAP_IDCODE_VAL;
      `BSTAP_IR_USERCODE: capt = nvm_user_i;
      `BSTAP_IR_IFONOFF: capt[0] = host_if_off_o;
      `BSTAP_IR_REGRD: capt[`BSTAP_WR_W-1:0] = {reg_rd_data_i, reg_rd_addr_o};
      default: capt = {`BSTAP_DR_W{1'b0}};
    endcase
  end

  // Pin drive: boundary cells override the core under EXTEST and CLAMP; HIGHZ turns every pin enable off
  always @* begin
    m = 0;
    next_pin_out = core_out_i;
    next_pin_oe = core_oe_i;
    if (ir == `BSTAP_IR_HIGHZ) begin
      next_pin_oe = {`BSTAP_PINS{1'b0}};
    end else if (test_drive) begin
      for (m = 0; m < `BSTAP_PINS; m = m + 1) begin
        next_pin_out[m] = bsr_upd[2*m];
        next_pin_oe[m] = bsr_upd[2*m+1];
      end
    end
  end

  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      tck_d <= 1'b0;
      warm <= 2'h0;
      pin_out_o <= {`BSTAP_PINS{1'b0}};
      pin_oe_o <= {`BSTAP_PINS{1'b0}};
    end else begin
      tck_d <= tck_s;
      if (!armed) begin
        warm <= warm + 2'h1;
      end
      pin_out_o <= next_pin_out;
      pin_oe_o <= next_pin_oe;
    end
  end

  // Controller, instruction and data chains on the rising test clock
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      state <= ST_TLR;
      ir <= `BSTAP_IR_IDCODE;
      ir_sh <= `BSTAP_IR_CAPT;
      dr_sh <= {`BSTAP_DR_W{1'b0}};
      bsr_upd <= {`BSTAP_BSR_W{1'b0}};
      host_if_off_o <= 1'b0;
      reg_rd_addr_o <= {`BSTAP_ADDR_W{1'b0}};
      wr_push <= 1'b0;
      wr_word <= {`BSTAP_WR_W{1'b0}};
      wr_overrun_o <= 1'b0;
    end else begin
      wr_push <= 1'b0;
      if (tck_rise) begin
        state <= tap_next(state, tms_s);
        case (state)
          ST_TLR: begin
            ir <= `BSTAP_IR_IDCODE;
          end
          ST_SEL_IR: begin
            if (tms_s) begin
              ir <= `BSTAP_IR_IDCODE;
            end
          end
          ST_CAP_IR: begin
            ir_sh <= `BSTAP_IR_CAPT;
          end
          ST_SH_IR: begin
            ir_sh <= {tdi_s, ir_sh[`BSTAP_IR_W-1:1]};
          end
          ST_UPD_IR: begin
            ir <= ir_sh;
          end
          ST_CAP_DR: begin
            dr_sh <= capt;
          end
          ST_SH_DR: begin
            dr_sh <= shift_in(dr_sh, tdi_s, cur_len);
          end
          ST_UPD_DR: begin
            case (ir)
              `BSTAP_IR_SAMPLE, `BSTAP_IR_EXTEST: begin
                bsr_upd <= dr_sh[`BSTAP_BSR_W-1:0];
              end
              `BSTAP_IR_IFONOFF: begin
                host_if_off_o <= dr_sh[0];
              end
              `BSTAP_IR_REGRD: begin
                if (host_if_off_o) begin
                  reg_rd_addr_o <= dr_sh[`BSTAP_ADDR_W-1:0];
                end
              end
              `BSTAP_IR_REGWR: begin
                if (host_if_off_o && buf_in_ready) begin
                  wr_word <= dr_sh[`BSTAP_WR_W-1:0];
                  wr_push <= 1'b1;
                end else if (host_if_off_o) begin
                  wr_overrun_o <= 1'b1;
                end
              end
              default: begin
                bsr_upd <= bsr_upd;
              end
            endcase
          end
          default: begin
            ir_sh <= ir_sh;
          end
        endcase
      end
    end
  end

  // Serial output on the falling test clock, driven only while shifting
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (tck_fall) begin
      tdo_o <= (state == ST_SH_IR) ? ir_sh[0] : dr_sh[0];
      tdo_oe_o <= (state == ST_SH_IR) || (state == ST_SH_DR);
    end
  end

endmodule

`default_nettype wire

// ===== bench/bstap_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "bstap_defs.vh"
module bstap_checker (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic tck_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_o,
  input wire logic [`BSTAP_PINS-1:0] pin_out_o,
  input wire logic [`BSTAP_PINS-1:0] pin_oe_o,
  input wire logic host_if_off_o,
  input wire logic [`BSTAP_ADDR_W-1:0] reg_rd_addr_o,
  input wire logic reg_wr_valid_o,
  input wire logic reg_wr_ready_i,
  input wire logic [`BSTAP_ADDR_W-1:0] reg_wr_addr_o,
  input wire logic [`BSTAP_DATA_W-1:0] reg_wr_data_o,
  input wire logic wr_overrun_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  a_tdo_reset: assert property (disable iff (1'b0) !nrst_i |=> !tdo_oe_o && !tdo_o) else $error("tdo rst");
  a_out_reset: assert property (disable iff (1'b0) !nrst_i |=> pin_oe_o == 0 && !host_if_off_o
    && !reg_wr_valid_o && !wr_overrun_o) else $error("out rst");
  a_tdo_fall: assert property ($changed(tdo_o) |-> !$past(tck_i, 2)) else $error("tdo edge");
  a_oe_fall: assert property ($changed(tdo_oe_o) |-> !$past(tck_i, 2)) else $error("oe edge");
  a_tck_static: assert property ($stable(tck_i) [*8] |-> $stable(tdo_o)) else $error("static");
  a_if_rise: assert property ($changed(host_if_off_o) |-> $past(tck_i, 3)) else $error("if");
  a_addr_gate: assert property ($changed(reg_rd_addr_o) |-> host_if_off_o && $past(tck_i, 3))
    else $error("addr");
  a_wr_rise: assert property ($rose(reg_wr_valid_o) |-> host_if_off_o && $past(tck_i, 3))
    else $error("wr rise");
  a_wr_hold: assert property (reg_wr_valid_o && !reg_wr_ready_i |=> reg_wr_valid_o
    && $stable(reg_wr_addr_o) && $stable(reg_wr_data_o)) else $error("wr hold");
  a_ovr_sticky: assert property (wr_overrun_o |=> wr_overrun_o) else $error("ovr");
  c_pop: cover property (reg_wr_valid_o && reg_wr_ready_i);
  c_ovr: cover property ($rose(wr_overrun_o));
  c_shift: cover property ($rose(tdo_oe_o));
endmodule
`default_nettype wire

// ===== bench/bstap_ctl.sv
`timescale 1ns/10ps
`default_nettype none
module bstap_ctl (
  input wire logic mclk_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i,
  input wire logic tdo_oe_i
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  // One 32 ns test clock; called at an edge, clock stands high afterwards
  task automatic tick(input logic m, input logic d, output logic o);
    tck_o <= 1'b0;
    tms_o <= m;
    tdi_o <= d;
    repeat (4) @(posedge mclk_i);
    tck_o <= 1'b1;
    repeat (4) @(posedge mclk_i);
    // A released output reads as its inverse
    o = tdo_oe_i ? tdo_i : ~tdo_i;
  endtask
endmodule
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "bstap_defs.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module tb;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic tck, tms, tdi, tdo, tdo_oe, if_off, wr_valid, wr_ready, overrun;
  logic [11:0] pin_in, core_out, core_oe, pin_out, pin_oe;
  logic [31:0] nvm_user;
  logic [6:0] rd_addr, wr_addr;
  logic [7:0] rd_data, wr_data;
  int err_total = 0;
  int comparisons = 0;
  bstap_ctl i_ctl (.mclk_i(mclk_i), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(tdo_oe));
  bstap_top i_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe), .pin_in_i(pin_in), .core_out_i(core_out), .core_oe_i(core_oe), .pin_out_o(pin_out),
    .pin_oe_o(pin_oe), .nvm_user_i(nvm_user), .host_if_off_o(if_off), .reg_rd_addr_o(rd_addr),
    .reg_rd_data_i(rd_data), .reg_wr_valid_o(wr_valid), .reg_wr_ready_i(wr_ready), .reg_wr_addr_o(wr_addr),
    .reg_wr_data_o(wr_data), .wr_overrun_o(overrun));
  always #2 mclk_i = ~mclk_i;
  // Register file model answering the read address
  always @(posedge mclk_i) rd_data <= {1'b0, rd_addr} ^ 8'h5A;
  task automatic complete_run;
    if (err_total == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic tk(input logic m);
    logic o;
    i_ctl.tick(m, 1'b1, o);
  endtask
  task automatic settle;
    repeat (8) @(posedge mclk_i);
  endtask
  task automatic ir(input logic [3:0] code);
    logic [3:0] o;
    tk(1); tk(1); tk(0); tk(0);
    for (int i = 0; i < 4; i++) i_ctl.tick(i == 3, code[i], o[i]);
    tk(1); tk(0);
    `CHK(o, `BSTAP_IR_CAPT)
  endtask
  task automatic dr(input logic [31:0] din, input int n, output logic [31:0] dout);
    dout = '0;
    tk(1); tk(0); tk(0);
    for (int i = 0; i < n; i++) begin
      i_ctl.tick(i == n - 1, din[i], dout[i]);
      `CHK(tdo_oe, 1'b1)
    end
    tk(1); tk(0);
    `CHK(tdo_oe, 1'b0)
  endtask
  task automatic t_id_bypass;
    logic [31:0] o;
    dr(32'h0, 32, o);
    `CHK(o, `BSTAP_IDCODE_VAL)
    ir(`BSTAP_IR_BYPASS);
    dr(32'hB5, 9, o);
    `CHK(o[8:0], 9'h16A)
    repeat (5) tk(1);
    tk(0);
    dr(32'h0, 32, o);
    `CHK(o, `BSTAP_IDCODE_VAL)
  endtask
  task automatic t_user;
    logic [31:0] o;
    ir(`BSTAP_IR_USERCODE);
    dr(32'hFFFF0000, 32, o);
    `CHK(o, nvm_user)
    ir(`BSTAP_IR_IDCODE);
    dr(32'h0, 32, o);
    `CHK(o, `BSTAP_IDCODE_VAL)
  endtask
  task automatic t_boundary;
    logic [31:0] o;
    logic [23:0] p;
    p = 24'h5AC396;
    ir(`BSTAP_IR_SAMPLE);
    dr({p, 8'hE7}, 32, o);
    `CHK(o[31:24], 8'hE7)
    for (int k = 0; k < 12; k++) `CHK({o[2*k+1], o[2*k]}, {core_oe[k], pin_in[k]})
    ir(`BSTAP_IR_EXTEST);
    settle;
    for (int k = 0; k < 12; k++) `CHK({pin_oe[k], pin_out[k]}, p[2*k+1 -: 2])
    ir(`BSTAP_IR_CLAMP);
    dr(32'h1, 2, o);
    `CHK(o[1:0], 2'b10)
    for (int k = 0; k < 12; k++) `CHK({pin_oe[k], pin_out[k]}, p[2*k+1 -: 2])
    ir(`BSTAP_IR_HIGHZ);
    settle;
    `CHK(pin_oe, 12'h000)
    ir(`BSTAP_IR_BYPASS);
    settle;
    `CHK({pin_oe, pin_out}, {core_oe, core_out})
  endtask
  task automatic t_regs;
    logic [31:0] o;
    logic [14:0] w [3];
    w = '{15'h2A15, 15'h55EA, 15'h7F01};
    ir(`BSTAP_IR_REGWR);
    dr({17'h0, w[2]}, 15, o);
    settle;
    `CHK({wr_valid, overrun}, 2'b00)
    ir(`BSTAP_IR_IFONOFF);
    dr(32'h1, 1, o);
    settle;
    `CHK({o[0], if_off}, 2'b01)
    ir(`BSTAP_IR_REGWR);
    for (int j = 0; j < 3; j++) dr({17'h0, w[j]}, 15, o);
    settle;
    `CHK(overrun, 1'b1)
    for (int j = 0; j < 2; j++) begin
      `CHK({wr_valid, wr_data, wr_addr}, {1'b1, w[j]})
      wr_ready <= 1'b1;
      @(posedge mclk_i);
      wr_ready <= 1'b0;
      @(posedge mclk_i);
    end
    `CHK(wr_valid, 1'b0)
    ir(`BSTAP_IR_REGRD);
    dr(32'h2A, 15, o);
    `CHK(o[14:0], {8'h5A, 7'h00})
    dr(32'h11, 15, o);
    settle;
    `CHK(o[14:0], {8'h2A ^ 8'h5A, 7'h2A})
    `CHK(rd_addr, 7'h11)
  endtask
  initial begin
    wr_ready = 1'b0;
    pin_in = 12'hA6C;
    core_out = 12'h3C5;
    core_oe = 12'h9A3;
    nvm_user = 32'hC1D2E3F4;
    repeat (4) @(posedge mclk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    tk(0);
    t_id_bypass;
    t_user;
    t_boundary;
    t_regs;
    complete_run;
  end
  initial begin
    repeat (40000) @(posedge mclk_i);
    err_total++;
    complete_run;
  end
endmodule
bind bstap_top bstap_checker i_chk (.mclk_i(mclk_i), .nrst_i(nrst_i), .tck_i(tck_i), .tdo_o(tdo_o),
  .tdo_oe_o(tdo_oe_o), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .host_if_off_o(host_if_off_o),
  .reg_rd_addr_o(reg_rd_addr_o), .reg_wr_valid_o(reg_wr_valid_o), .reg_wr_ready_i(reg_wr_ready_i),
  .reg_wr_addr_o(reg_wr_addr_o), .reg_wr_data_o(reg_wr_data_o), .wr_overrun_o(wr_overrun_o));
`default_nettype wire
